// file: hw/acr_regs.svh
/*
 Offsets, field positions, reset values and checksum constants of the
 channel-two calibration and converter control register slice.
 Assumes inclusion by bare name from every file that needs them.
*/
// Behaviour
// - Offset upper bits 23:8 stored read/write at 14h, reset zero.
// - Offset bits 7:0 in 15h bits 15:8; low byte reads zero.
// - Gain upper bits 23:8 stored read/write at 16h, reset 8000h.
// - Gain bits 7:0 in 17h bits 15:8, reset zero; low byte zero.
// - Gain is unsigned fixed point, 0.0 to just under 2.0.
// - Higher frequency-range code selects lower modulator frequency band.
// - Bit 0 of 31h turns converter on; reset off; reserved written zero.
// - Read-only 16-bit register map checksum at 3Eh, reset zero.
// - Programmed offset subtracted from each conversion result.
// - Offset-corrected result multiplied by gain factor every sample.
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

// Register offsets
`define ACR_OFS_OFF_HIGH 6'h14
`define ACR_OFS_OFF_LOW 6'h15
`define ACR_OFS_GAIN_HIGH 6'h16
`define ACR_OFS_GAIN_LOW 6'h17
`define ACR_OFS_CONV_CTRL 6'h31
`define ACR_OFS_CHECKSUM 6'h3E

// Reset values
`define ACR_RST_OFF_HIGH 16'h0000
`define ACR_RST_OFF_LOW 8'h00
`define ACR_RST_GAIN_HIGH 16'h8000
`define ACR_RST_GAIN_LOW 8'h00
`define ACR_RST_CONV_CTRL 16'h0000
`define ACR_RST_CHECKSUM 16'h0000

// Field positions
`define ACR_LOW_FIELD_MSB 15
`define ACR_LOW_FIELD_LSB 8
`define ACR_FREQ_MSB 11
`define ACR_FREQ_LSB 8
`define ACR_CONV_ON_BIT 0

// Gain has 23 fraction bits: 800000h is unity
`define ACR_GAIN_FRAC_BITS 23

// Checksum polynomial and seed
`define ACR_CRC_POLY 16'h1021
`define ACR_CRC_SEED 16'hFFFF

`endif

// file: hw/acr_pkg.sv
/*
 Types shared by the calibration register slice and its correction path.
 Assumes acr_regs.svh provides the numeric constants.
*/
package acr_pkg;

   // One conversion sample with its strobe
   typedef struct packed {
      logic valid;
      logic [23:0] data;
   } acr_sample_s;

   // Register host port request
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [5:0] addr;
      logic [15:0] wrData;
   } acr_req_s;

   // Register file and read path state
   typedef struct packed {
      logic [15:0] offHigh;
      logic [7:0] offLow;
      logic [15:0] gainHigh;
      logic [7:0] gainLow;
      logic [15:0] convCtrl;
      logic [15:0] checksum;
      logic [15:0] rdData;
      logic rdValid;
   } acr_bank_s;

   // Correction pipeline state
   typedef struct packed {
      logic diffValid;
      logic [24:0] diff;
      logic outValid;
      logic [23:0] outData;
   } acr_corr_s;

endpackage : acr_pkg

// file: hw/acr_corr.sv
/*
 Two-stage offset and gain correction of channel-two samples.
 Assumes samples arrive synchronous to clk with a one-cycle valid.
*/
`timescale 1ns/10ps
`include "acr_regs.svh"

module acr_corr (
   input wire logic clk,
   input wire logic rst_n,
   input acr_pkg::acr_sample_s sampleIn,
   input wire logic [23:0] offset,
   input wire logic [23:0] gain,
   output acr_pkg::acr_sample_s sampleOut
);
   import acr_pkg::*;

   localparam logic signed [49:0] SAT_MAX = 50'sh7FFFFF;
   localparam logic signed [49:0] SAT_MIN = -50'sh800000;

   acr_corr_s st_q;
   acr_corr_s st_d;
   logic signed [49:0] prod;
   logic signed [49:0] scaled;

   // Subtract offset, then scale by unsigned gain and saturate
   always_comb begin
      st_d = st_q;
      st_d.diffValid = sampleIn.valid;
      if (sampleIn.valid) begin
         st_d.diff = {sampleIn.data[23], sampleIn.data} - {offset[23], offset};
      end
      prod = 50'($signed(st_q.diff)) * 50'($signed({1'b0, gain}));
      scaled = prod >>> `ACR_GAIN_FRAC_BITS;
      st_d.outValid = st_q.diffValid;
      if (st_q.diffValid) begin
         if (scaled > SAT_MAX) begin
            st_d.outData = 24'h7FFFFF;
         end else if (scaled < SAT_MIN) begin
            st_d.outData = 24'h800000;
         end else begin
            st_d.outData = scaled[23:0];
         end
      end
   end

   // Pipeline registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sampleOut.valid = st_q.outValid;
   assign sampleOut.data = st_q.outData;

endmodule : acr_corr

// file: hw/acr_cal_regs.sv
/*
 Channel-two offset and gain calibration registers, isolated converter
 control, register map checksum, and the correction path they steer.
 Assumes the serial front end has already framed each access into a
 one-cycle write or read strobe with a six-bit register address.
*/
`timescale 1ns/10ps
`include "acr_regs.svh"

module acr_cal_regs (
   input wire logic clk,
   input wire logic rst_n,
   input acr_pkg::acr_req_s req,
   output logic [15:0] regRdData,
   output logic regRdValid,
   input acr_pkg::acr_sample_s sampleIn,
   output acr_pkg::acr_sample_s sampleOut,
   output logic converterOn,
   output logic [3:0] converterFreqRange
);
   import acr_pkg::*;

   acr_bank_s st_q;
   acr_bank_s st_d;
   logic [15:0] crcNow;
   logic [23:0] offsetWord;
   logic [23:0] gainWord;

   // One CRC step over a 16-bit word, MSB first
   function automatic logic [15:0] acrCrcWord(input logic [15:0] crcIn, input logic [15:0] word);
      logic [15:0] c;
      c = crcIn;
      for (int i = 15; i >= 0; i--) begin
         if (c[15] ^ word[i]) begin
            c = {c[14:0], 1'b0} ^ `ACR_CRC_POLY;
         end else begin
            c = {c[14:0], 1'b0};
         end
      end
      return c;
   endfunction : acrCrcWord

   // Read image of a low register: field in the high byte, zero below
   function automatic logic [15:0] acrLowImage(input logic [7:0] field);
      return {field, 8'h00};
   endfunction : acrLowImage

   // Value software reads at a given address; unmapped reads as zero
   function automatic logic [15:0] acrReadMux(input acr_bank_s s, input logic [5:0] addr);
      logic [15:0] v;
      v = 16'h0000;
      unique case (addr)
         `ACR_OFS_OFF_HIGH: begin
            v = s.offHigh;
         end
         `ACR_OFS_OFF_LOW: begin
            v = acrLowImage(s.offLow);
         end
         `ACR_OFS_GAIN_HIGH: begin
            v = s.gainHigh;
         end
         `ACR_OFS_GAIN_LOW: begin
            v = acrLowImage(s.gainLow);
         end
         `ACR_OFS_CONV_CTRL: begin
            v = s.convCtrl;
         end
         `ACR_OFS_CHECKSUM: begin
            v = s.checksum;
         end
         default: begin
            v = 16'h0000;
         end
      endcase
      return v;
   endfunction : acrReadMux

   // Checksum over every configuration word as software reads it
   always_comb begin
      crcNow = `ACR_CRC_SEED;
      crcNow = acrCrcWord(crcNow, st_q.offHigh);
      crcNow = acrCrcWord(crcNow, acrLowImage(st_q.offLow));
      crcNow = acrCrcWord(crcNow, st_q.gainHigh);
      crcNow = acrCrcWord(crcNow, acrLowImage(st_q.gainLow));
      crcNow = acrCrcWord(crcNow, st_q.convCtrl);
   end

   // Next state: writes, checksum refresh and registered read answer
   always_comb begin
      st_d = st_q;
      st_d.rdValid = 1'b0;
      if (req.wrEn) begin
         unique case (req.addr)
            `ACR_OFS_OFF_HIGH: begin
               st_d.offHigh = req.wrData;
            end
            `ACR_OFS_OFF_LOW: begin
               st_d.offLow = req.wrData[`ACR_LOW_FIELD_MSB:`ACR_LOW_FIELD_LSB];
            end
            `ACR_OFS_GAIN_HIGH: begin
               st_d.gainHigh = req.wrData;
            end
            `ACR_OFS_GAIN_LOW: begin
               st_d.gainLow = req.wrData[`ACR_LOW_FIELD_MSB:`ACR_LOW_FIELD_LSB];
            end
            `ACR_OFS_CONV_CTRL: begin
               st_d.convCtrl = req.wrData;
            end
            default: begin
               st_d.convCtrl = st_q.convCtrl; // Checksum and unmapped ignore writes
            end
         endcase
      end
      // Checksum follows the stored settings one cycle behind
      st_d.checksum = crcNow;
      if (req.rdEn) begin
         st_d.rdData = acrReadMux(st_q, req.addr);
         st_d.rdValid = 1'b1;
      end
   end

   // State register with documented reset values
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q.offHigh <= `ACR_RST_OFF_HIGH;
         st_q.offLow <= `ACR_RST_OFF_LOW;
         st_q.gainHigh <= `ACR_RST_GAIN_HIGH;
         st_q.gainLow <= `ACR_RST_GAIN_LOW;
         st_q.convCtrl <= `ACR_RST_CONV_CTRL;
         st_q.checksum <= `ACR_RST_CHECKSUM;
         st_q.rdData <= 16'h0000;
         st_q.rdValid <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // Read port
   assign regRdData = st_q.rdData;
   assign regRdValid = st_q.rdValid;

   // Converter control pins; the band meaning of the code lies in the analog
   // oscillator: larger code, lower modulator band
   assign converterOn = st_q.convCtrl[`ACR_CONV_ON_BIT];
   assign converterFreqRange = st_q.convCtrl[`ACR_FREQ_MSB:`ACR_FREQ_LSB];

   // Assemble 24-bit correction words
   assign offsetWord = {st_q.offHigh, st_q.offLow};
   assign gainWord = {st_q.gainHigh, st_q.gainLow};

   // Offset then gain correction on every sample
   acr_corr u_corr (
      .clk(clk),
      .rst_n(rst_n),
      .sampleIn(sampleIn),
      .offset(offsetWord),
      .gain(gainWord),
      .sampleOut(sampleOut)
   );

endmodule : acr_cal_regs

// file: tb/acr_cal_regs_chk.sv
/* Port checker for the calibration register slice.
   Assumes a bind onto acr_cal_regs. */
`timescale 1ns/10ps
module acr_cal_regs_chk (
   input wire logic clk,
   input wire logic rst_n,
   input acr_pkg::acr_req_s req,
   input wire logic [15:0] regRdData,
   input wire logic regRdValid,
   input acr_pkg::acr_sample_s sampleIn,
   input acr_pkg::acr_sample_s sampleOut,
   input wire logic converterOn,
   input wire logic [3:0] converterFreqRange
);
   import acr_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Read answers and reserved bytes
   a_rd_answer: assert property (req.rdEn |=> regRdValid) else $error("read unanswered");
   a_rd_cause: assert property (regRdValid |-> $past(req.rdEn)) else $error("stray answer");
   a_low_zero: assert property (regRdValid && ($past(req.addr) == 6'h15 || $past(req.addr) == 6'h17)
      |-> regRdData[7:0] == 8'h00) else $error("low byte set");
   // Converter control follows writes only
   a_conv_on: assert property (req.wrEn && req.addr == 6'h31 |=> converterOn == $past(req.wrData[0]))
      else $error("enable wrong");
   a_freq_code: assert property (req.wrEn && req.addr == 6'h31 |=> converterFreqRange == $past(req.wrData[11:8]))
      else $error("range wrong");
   a_conv_hold: assert property (!(req.wrEn && req.addr == 6'h31) |=> $stable(converterOn) && $stable(converterFreqRange))
      else $error("control moved");
   // Correction pipeline timing
   a_smp_lat: assert property (sampleIn.valid |-> ##2 sampleOut.valid) else $error("sample lost");
   a_smp_cause: assert property (sampleOut.valid |-> $past(sampleIn.valid, 2)) else $error("stray sample");
endmodule : acr_cal_regs_chk

// file: tb/acr_host_model.sv
/* Host side of the register port, one request per falling edge.
   Assumes the bench calls op and idle in order. */
`timescale 1ns/10ps
module acr_host_model (
   input wire logic clk,
   output acr_pkg::acr_req_s req
);
   import acr_pkg::*;
   initial req = '0;
   // Present a request for the next rising edge
   task automatic op(input logic w, input logic r, input logic [5:0] a, input logic [15:0] d);
      @(negedge clk);
      req.wrEn = w;
      req.rdEn = r;
      req.addr = a;
      req.wrData = (a == 6'h31) ? (d & 16'h0F01) : d;
   endtask : op
   // Drop strobes; stale lines flip
   task automatic idle();
      @(negedge clk);
      req = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~req.addr, wrData: ~req.wrData};
   endtask : idle
endmodule : acr_host_model

// file: tb/tb.sv
/* Bench: register and correction model compared at every result.
   Assumes acr_host_model on the register port. */
`timescale 1ns/10ps
`include "acr_regs.svh"
module tb;
   import acr_pkg::*;
   logic clk = 0;
   logic rst_n = 0;
   acr_req_s req;
   logic [15:0] regRdData;
   logic regRdValid;
   acr_sample_s sampleIn = '0;
   acr_sample_s sampleOut;
   logic converterOn;
   logic [3:0] converterFreqRange;
   int num_errors = 0;
   int cmp_count = 0;
   logic [31:0] seed = 32'h6;
   logic [15:0] crcLag = 16'h0000;
   logic [15:0] regM [64];
   logic [23:0] rdQ [$];
   logic [23:0] smpQ [$];
   logic [5:0] addrTab [8] = '{6'h14, 6'h15, 6'h16, 6'h17, 6'h31, 6'h3E, 6'h20, 6'h00};
   always #50 clk = ~clk;
   acr_host_model host (.clk(clk), .req(req));
   acr_cal_regs dut (.clk(clk), .rst_n(rst_n), .req(req), .regRdData(regRdData), .regRdValid(regRdValid),
      .sampleIn(sampleIn), .sampleOut(sampleOut), .converterOn(converterOn), .converterFreqRange(converterFreqRange));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
   endfunction : lfsr
   // Checksum of the modelled read images, MSB first
   function automatic logic [15:0] crcOf();
      logic [15:0] c;
      logic [5:0] w [5];
      c = `ACR_CRC_SEED;
      w = '{6'h14, 6'h15, 6'h16, 6'h17, 6'h31};
      foreach (w[j]) begin
         for (int i = 15; i >= 0; i--) begin
            c = (c << 1) ^ ((c[15] ^ regM[w[j]][i]) ? `ACR_CRC_POLY : 16'h0000);
         end
      end
      return c;
   endfunction : crcOf
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   // Answers and samples in order
   always @(negedge clk) begin
      if (regRdValid === 1'b1) check({8'h00, regRdData}, rdQ.size() ? rdQ.pop_front() : 24'hFFFFFF);
      if (sampleOut.valid === 1'b1) check(sampleOut.data, smpQ.size() ? smpQ.pop_front() : 24'hXXXXXX);
   end
   // Request; read sees old value, checksum trails the last write by one edge
   task automatic xf(input logic w, input logic r, input logic [5:0] a, input logic [15:0] d);
      if (r) rdQ.push_back({8'h00, ((a == 6'h3E) ? crcLag : regM[a])});
      host.op(w, r, a, d);
      crcLag = crcOf();
      if (w && a inside {6'h14, 6'h16, 6'h31}) regM[a] = host.req.wrData;
      if (w && a inside {6'h15, 6'h17}) regM[a] = d & 16'hFF00;
   endtask : xf
   task automatic readall();
      for (int i = 0; i < 8; i++) xf(1'b0, 1'b1, addrTab[i], 16'h0000);
      host.idle();
      check({16'h0000, converterFreqRange, 3'b000, converterOn}, {16'h0000, regM[6'h31][11:8], 3'b000, regM[6'h31][0]});
   endtask : readall
   // Reset; checksum read at release
   task automatic rst();
      rst_n = 0;
      regM = '{default: 16'h0000};
      regM[6'h16] = 16'h8000;
      crcLag = crcOf();
      repeat (8) @(negedge clk);
      rdQ.push_back(24'h000000);
      fork
         host.op(1'b0, 1'b1, 6'h3E, 16'h0000);
         @(negedge clk) rst_n = 1;
      join
      readall();
   endtask : rst
   task automatic samples(input int n);
      longint x, o, g, y;
      o = $signed({regM[6'h14], regM[6'h15][15:8]});
      g = {regM[6'h16], regM[6'h17][15:8]};
      for (int i = 0; i < n; i++) begin
         seed = lfsr(seed);
         @(negedge clk);
         sampleIn = '{valid: seed[31], data: seed[23:0]};
         x = $signed(seed[23:0]);
         y = ((x - o) * g) >>> 23;
         if (y > 8388607) y = 8388607;
         if (y < -8388608) y = -8388608;
         if (seed[31]) smpQ.push_back(y[23:0]);
      end
      @(negedge clk);
      sampleIn = '{valid: 1'b0, data: ~sampleIn.data};
      repeat (3) @(negedge clk);
   endtask : samples
   initial begin
      rst();
      samples(12);
      // Back-to-back random writes
      for (int k = 0; k < 20; k++) begin
         seed = lfsr(seed);
         xf(1'b1, seed[20], addrTab[seed[2:0]], seed[31:16]);
      end
      readall();
      samples(24);
      // Largest gain, most negative offset
      xf(1'b1, 1'b0, 6'h16, 16'hFFFF);
      xf(1'b1, 1'b0, 6'h17, 16'hFFFF);
      xf(1'b1, 1'b0, 6'h14, 16'h8000);
      xf(1'b1, 1'b0, 6'h15, 16'h0000);
      readall();
      samples(16);
      rst();
      @(negedge clk); // Let the last answer drain
      check(24'(rdQ.size() + smpQ.size()), 24'h000000);
      summarize();
   end
   initial begin
      #2000000;
      num_errors++;
      summarize();
   end
endmodule : tb
bind acr_cal_regs acr_cal_regs_chk chk (.clk(clk), .rst_n(rst_n), .req(req), .regRdData(regRdData),
   .regRdValid(regRdValid), .sampleIn(sampleIn), .sampleOut(sampleOut), .converterOn(converterOn),
   .converterFreqRange(converterFreqRange));
